// File: hw/siaba_dev.sv
// device side of a ddr memory: command decode, bank state, 8n bursts
// assumes all pins come from the controller's domain and are slower than clk_i
// How it works
// - read strobe toggles with each read byte; write data sampled on strobe edges
// - strobe edges count only while true and complement differ
// - select bit set: termination on strobe pair; clear: pin is write mask
// - eight banks; each full burst moves one 64-bit word as eight bytes
// - bursts start at the column, run eight or four beats in programmed order
// - read or write takes column, auto-close bit and chop-select bit
// - device initialises 500 us after reset, ignoring commands meanwhile
// - commands with chip select high are ignored
// - auto-close bit: precharge after access; at precharge, all banks or one
// - on-the-fly mode: chop bit high gives eight beats, low gives four
`timescale 1ns/1ps
`default_nettype none
module siaba_dev
  import siaba_pkg::*;
#(
  parameter int INIT_CYC = INIT_WAIT_CYC,
  parameter int ROW_W = 4,
  parameter int COL_W = 6
) (
  // system
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // command pins
  input wire logic cmd_clk_t_i,
  input wire logic cmd_clk_c_i,
  input wire logic reset_n_i,
  input wire logic cke_i,
  input wire logic cs_n_i,
  input wire logic ras_n_i,
  input wire logic cas_n_i,
  input wire logic we_n_i,
  input wire logic [2:0] bank_select_bits_i,
  input wire logic [15:0] row_col_address_bits_i,
  // data pins
  input wire logic [7:0] byte_data_lines_i,
  output logic [7:0] byte_data_lines_o,
  output logic byte_data_lines_oe_o,
  input wire logic write_mask_i,
  input wire logic dqs_t_i,
  input wire logic dqs_c_i,
  output logic dqs_t_o,
  output logic dqs_c_o,
  output logic dqs_oe_o,
  // termination on the shared strobe pair
  output logic term_strobe_true_o,
  output logic term_strobe_comp_o
);
  localparam int IW = 3 + ROW_W + COL_W - 3;
  localparam int CW = $clog2(INIT_CYC + 1);

  logic [15:0] mode0_ff;
  logic [15:0] mode1_ff;
  logic [1:0] err_ff;
  logic [31:0] rd_mux;

  // every pin passes two flops first
  logic [37:0] pins_s;
  logic reset_n_s, cke_s, ck_t_s, ck_c_s, dqs_t_s, dqs_c_s, mask_s;
  logic [3:0] cmd_s;
  logic [2:0] ba_s;
  logic [15:0] a_s;
  logic [7:0] dq_s;

  siaba_sync #(.W(38)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({reset_n_i, cke_i, cs_n_i, ras_n_i, cas_n_i, we_n_i, bank_select_bits_i,
          row_col_address_bits_i, byte_data_lines_i, write_mask_i, dqs_t_i, dqs_c_i,
          cmd_clk_t_i, cmd_clk_c_i}),
    .q_o(pins_s)
  );
  assign {reset_n_s, cke_s, cmd_s, ba_s, a_s, dq_s, mask_s, dqs_t_s, dqs_c_s,
          ck_t_s, ck_c_s} = pins_s;

  // edge finding on the command clock and the strobe
  logic ck_prev_ff, dqs_prev_ff;
  logic ck_rise, ck_fall, link_edge, dqs_edge, strobe_pair_ok;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ck_prev_ff <= 1'b0;
      dqs_prev_ff <= 1'b0;
    end else begin
      ck_prev_ff <= ck_t_s;
      dqs_prev_ff <= dqs_t_s;
    end
  end
  assign ck_rise = ck_t_s && !ck_prev_ff && !ck_c_s;
  assign ck_fall = !ck_t_s && ck_prev_ff && ck_c_s;
  assign link_edge = ck_rise || ck_fall;
  assign strobe_pair_ok = dqs_t_s != dqs_c_s;
  assign dqs_edge = (dqs_t_s != dqs_prev_ff) && strobe_pair_ok;

  // internal initialisation runs off clk_i, not the link clock
  logic [CW-1:0] init_cnt_ff;
  logic init_busy;
  always_ff @(posedge clk_i) begin
    if (rst_i || !reset_n_s) begin
      init_cnt_ff <= CW'(INIT_CYC);
    end else if (init_cnt_ff != '0) begin
      init_cnt_ff <= init_cnt_ff - CW'(1);
    end
  end
  assign init_busy = init_cnt_ff != '0;

  // command decode, only after init and with clock enable high
  logic cmd_ok, is_act, is_rd, is_wr, is_pre, chop;
  logic [7:0] bank_open_ff;
  logic [15:0] open_row_ff [NUM_BANKS];
  assign cmd_ok = ck_rise && reset_n_s && !init_busy && cke_s && !cmd_s[3];
  assign is_act = cmd_ok && cmd_s == CMD_ACT;
  assign is_rd = cmd_ok && cmd_s == CMD_RD && bank_open_ff[ba_s];
  assign is_wr = cmd_ok && cmd_s == CMD_WR && bank_open_ff[ba_s];
  assign is_pre = cmd_ok && cmd_s == CMD_PRE;
  assign chop = (mode0_ff[MODE0_BL_LSB+:2] == BL_FIXED4) ||
                (mode0_ff[MODE0_BL_LSB+:2] == BL_OTF && !a_s[ADDR_CHOP_BIT]);

  siaba_state_t state_ff;
  logic [2:0] bst_bank_ff;
  logic [2:0] bst_start_ff;
  logic [IW-1:0] bst_idx_ff;
  logic bst_close_ff;
  logic [3:0] bst_len_ff;
  logic [3:0] beat_ff;
  logic [63:0] pf_ff;
  logic [63:0] wbuf_ff;
  logic [7:0] skip_ff;
  logic [63:0] mem_q [2**IW];
  logic [IW-1:0] cmd_idx;
  logic [2:0] beat_pos;
  logic burst_done;

  assign cmd_idx = {ba_s, open_row_ff[ba_s][ROW_W-1:0], a_s[COL_W-1:3]};
  // sequential wraps inside each half, interleaved is an xor
  assign beat_pos = mode0_ff[MODE0_BT_BIT] ? (bst_start_ff ^ beat_ff[2:0]) :
                    {bst_start_ff[2] ^ beat_ff[2],
                     2'(bst_start_ff[1:0] + beat_ff[1:0])};
  assign burst_done = (state_ff == ST_READ && link_edge && beat_ff == bst_len_ff) ||
                      state_ff == ST_COMMIT;

  // bank and row tracking
  always_ff @(posedge clk_i) begin
    if (rst_i || !reset_n_s) begin
      bank_open_ff <= 8'h00;
      for (int b = 0; b < NUM_BANKS; b++) begin
        open_row_ff[b] <= 16'h0000;
      end
    end else begin
      if (is_act) begin
        bank_open_ff[ba_s] <= 1'b1;
        open_row_ff[ba_s] <= a_s;
      end else if (is_pre) begin
        if (a_s[ADDR_CLOSE_BIT]) begin
          bank_open_ff <= 8'h00;
        end else begin
          bank_open_ff[ba_s] <= 1'b0;
        end
      end
      if (burst_done && bst_close_ff) begin
        bank_open_ff[bst_bank_ff] <= 1'b0;
      end
    end
  end

  // burst state machine
  always_ff @(posedge clk_i) begin
    if (rst_i || !reset_n_s) begin
      state_ff <= ST_IDLE;
      beat_ff <= 4'h0;
      bst_bank_ff <= 3'h0;
      bst_start_ff <= 3'h0;
      bst_idx_ff <= '0;
      bst_close_ff <= 1'b0;
      bst_len_ff <= BURST_FULL;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          if (is_rd || is_wr) begin
            state_ff <= is_rd ? ST_READ : ST_WRITE;
            beat_ff <= 4'h0;
            bst_bank_ff <= ba_s;
            bst_start_ff <= a_s[2:0];
            bst_idx_ff <= cmd_idx;
            bst_close_ff <= a_s[ADDR_CLOSE_BIT];
            bst_len_ff <= chop ? BURST_CHOP : BURST_FULL;
          end
        end
        ST_READ: begin
          if (link_edge) begin
            beat_ff <= beat_ff + 4'h1;
            if (beat_ff == bst_len_ff) begin
              state_ff <= ST_IDLE;
            end
          end
        end
        ST_WRITE: begin
          if (dqs_edge) begin
            beat_ff <= beat_ff + 4'h1;
            if (beat_ff == bst_len_ff - 4'h1) begin
              state_ff <= ST_COMMIT;
            end
          end
        end
        ST_COMMIT: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // 8n prefetch: whole word read at the command, unmasked captured bytes written at the end
  always_ff @(posedge clk_i) begin
    if (state_ff == ST_IDLE && is_rd) begin
      pf_ff <= mem_q[cmd_idx];
    end
    if (state_ff == ST_COMMIT) begin
      for (int g = 0; g < 8; g++) begin
        if (!skip_ff[g]) begin
          mem_q[bst_idx_ff][g*8+:8] <= wbuf_ff[g*8+:8];
        end
      end
    end
  end

  // write capture; mask pin only counts when termination is off
  always_ff @(posedge clk_i) begin
    if (rst_i || state_ff == ST_IDLE) begin
      wbuf_ff <= 64'h0;
      skip_ff <= 8'hff;
    end else if (state_ff == ST_WRITE && dqs_edge) begin
      wbuf_ff[beat_pos*8+:8] <= dq_s;
      skip_ff[beat_pos] <= mask_s && !mode1_ff[MODE1_TSEL_BIT];
    end
  end

  // read drive: strobe follows the link clock, data changes on the same edge
  always_ff @(posedge clk_i) begin
    if (rst_i || !reset_n_s) begin
      byte_data_lines_o <= 8'h00;
      byte_data_lines_oe_o <= 1'b0;
      dqs_t_o <= 1'b0;
      dqs_c_o <= 1'b1;
      dqs_oe_o <= 1'b0;
    end else if (state_ff == ST_READ && link_edge) begin
      if (beat_ff < bst_len_ff) begin
        byte_data_lines_o <= pf_ff[beat_pos*8+:8];
        byte_data_lines_oe_o <= 1'b1;
        dqs_t_o <= ck_rise;
        dqs_c_o <= !ck_rise;
        dqs_oe_o <= 1'b1;
      end else begin
        byte_data_lines_oe_o <= 1'b0;
        dqs_oe_o <= 1'b0;
      end
    end
  end

  // termination on the pair only while receiving write strobes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      term_strobe_true_o <= 1'b0;
      term_strobe_comp_o <= 1'b0;
    end else begin
      term_strobe_true_o <= mode1_ff[MODE1_TSEL_BIT] && state_ff == ST_WRITE;
      term_strobe_comp_o <= mode1_ff[MODE1_TSEL_BIT] && state_ff == ST_WRITE;
    end
  end

  // wishbone slave: one wait-free answer, unmapped reads zero
  logic wb_req, wb_wr;
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr = wb_req && wb_we_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode0_ff <= MODE0_RST;
      mode1_ff <= MODE1_RST;
    end else if (wb_wr) begin
      if (wb_adr_i == ADR_MODE0) begin
        if (wb_sel_i[0]) mode0_ff[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1]) mode0_ff[15:8] <= wb_dat_i[15:8];
      end
      if (wb_adr_i == ADR_MODE1) begin
        if (wb_sel_i[0]) mode1_ff[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1]) mode1_ff[15:8] <= wb_dat_i[15:8];
      end
    end
  end

  // sticky errors; a new event beats a write-one clear
  logic [1:0] err_set, err_clr;
  assign err_set[ERR_STROBE_SE] = state_ff == ST_WRITE && !strobe_pair_ok;
  assign err_set[ERR_CLOSED_BANK] = cmd_ok && (cmd_s == CMD_RD || cmd_s == CMD_WR) &&
                                    !bank_open_ff[ba_s];
  assign err_clr = (wb_wr && wb_adr_i == ADR_ERROR && wb_sel_i[0]) ? wb_dat_i[1:0] : 2'h0;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err_ff <= 2'h0;
    end else begin
      err_ff <= (err_ff & ~err_clr) | err_set;
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (wb_adr_i)
      ADR_MODE0: rd_mux[15:0] = mode0_ff;
      ADR_MODE1: rd_mux[15:0] = mode1_ff;
      ADR_STATUS: begin
        rd_mux[ST_INIT_BIT] = init_busy;
        rd_mux[ST_RESET_BIT] = reset_n_s;
        rd_mux[ST_CKE_BIT] = cke_s;
        rd_mux[ST_BURST_BIT] = state_ff != ST_IDLE;
        rd_mux[ST_OPEN_LSB+:8] = bank_open_ff;
      end
      ADR_ERROR: rd_mux[1:0] = err_ff;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd_mux : 32'h0000_0000;
    end
  end

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_single: assert property (wb_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("wishbone ack not a single cycle");
  a_strobe_pair: assert property (dqs_oe_o |-> dqs_t_o != dqs_c_o)
    else $error("read strobe not complementary");
  a_strobe_edge: assert property ((state_ff == ST_READ && link_edge && beat_ff < bst_len_ff)
    |=> dqs_oe_o && dqs_t_o == $past(ck_rise))
    else $error("read strobe not aligned to link edge");
  a_term_off: assert property (!mode1_ff[MODE1_TSEL_BIT] |=> !term_strobe_true_o)
    else $error("termination active with select clear");
  a_cs_ignored: assert property ((ck_rise && cmd_s[3] && state_ff == ST_IDLE)
    |=> state_ff == ST_IDLE)
    else $error("deselected command started a burst");
  a_init_quiet: assert property ((init_busy && state_ff == ST_IDLE)
    |=> state_ff == ST_IDLE && $stable(bank_open_ff))
    else $error("command taken during initialisation");
  a_chop_len: assert property ((state_ff == ST_IDLE && is_rd &&
    mode0_ff[MODE0_BL_LSB+:2] == BL_OTF) |=> bst_len_ff ==
    ($past(a_s[ADDR_CHOP_BIT]) ? BURST_FULL : BURST_CHOP))
    else $error("on-the-fly burst length wrong");
  a_auto_close: assert property ((state_ff == ST_COMMIT && bst_close_ff && !is_act)
    |=> !bank_open_ff[$past(bst_bank_ff)])
    else $error("bank left open after auto-close");
  a_read_close: assert property ((state_ff == ST_READ && link_edge && beat_ff == bst_len_ff &&
    bst_close_ff && !is_act) |=> !bank_open_ff[$past(bst_bank_ff)])
    else $error("bank left open after auto-close read");
  a_read_ends: assert property ((state_ff == ST_READ && link_edge && beat_ff == bst_len_ff)
    |=> state_ff == ST_IDLE && !dqs_oe_o)
    else $error("read burst ran past its length");
  a_write_beats: assert property ($rose(state_ff == ST_COMMIT)
    |-> $past(beat_ff) == bst_len_ff - 4'h1)
    else $error("write burst committed at wrong beat");
endmodule : siaba_dev
`default_nettype wire

// File: hw/siaba_pkg.sv
// constants for the eight-bank ddr memory device model
// assumes a 25 mhz system clock and a wishbone register port
package siaba_pkg;
  // system clock and power-up wait
  localparam int CLK_PERIOD_NS = 40;
  localparam int INIT_WAIT_NS = 500000;
  localparam int INIT_WAIT_CYC = (INIT_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // register byte offsets
  localparam logic [7:0] ADR_MODE0 = 8'h00;
  localparam logic [7:0] ADR_MODE1 = 8'h04;
  localparam logic [7:0] ADR_STATUS = 8'h08;
  localparam logic [7:0] ADR_ERROR = 8'h0c;

  // reset values
  localparam logic [15:0] MODE0_RST = 16'h0000;
  localparam logic [15:0] MODE1_RST = 16'h0000;

  // field positions
  localparam int MODE0_BL_LSB = 0;
  localparam int MODE0_BT_BIT = 3;
  localparam int MODE1_TSEL_BIT = 11;
  localparam int ADDR_CLOSE_BIT = 10;
  localparam int ADDR_CHOP_BIT = 12;
  localparam int ERR_STROBE_SE = 0;
  localparam int ERR_CLOSED_BANK = 1;
  localparam int ST_INIT_BIT = 0;
  localparam int ST_RESET_BIT = 1;
  localparam int ST_CKE_BIT = 2;
  localparam int ST_BURST_BIT = 3;
  localparam int ST_OPEN_LSB = 8;

  // burst length field
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [1:0] BL_FIXED4 = 2'h2;
  localparam logic [3:0] BURST_FULL = 4'h8;
  localparam logic [3:0] BURST_CHOP = 4'h4;

  // commands as {select_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_RD = 4'h5;
  localparam logic [3:0] CMD_WR = 4'h4;
  localparam logic [3:0] CMD_PRE = 4'h2;

  localparam int NUM_BANKS = 8;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_READ = 4'b0010,
    ST_WRITE = 4'b0100,
    ST_COMMIT = 4'b1000
  } siaba_state_t;
endpackage : siaba_pkg

// File: hw/siaba_sync.sv
// two-stage synchroniser for a vector of pins
// assumes each bit is an independent level from outside clk_i
`timescale 1ns/1ps
`default_nettype none
module siaba_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // pins in, synchronised out
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // first stage feeds only the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= d_i;
      sync_ff <= meta_ff;
    end
  end

  assign q_o = sync_ff;
endmodule : siaba_sync
`default_nettype wire

// File: testbench/siaba_ctrl_model.sv
// controller model: link clock, commands, write bursts, read capture
// assumes clk_i is the device clock, used to time every link half, strobe step and power-up wait
`timescale 1ns/1ps
`default_nettype none
module siaba_ctrl_model
  import siaba_pkg::*;
#(
  parameter int RST_CYC = 8,
  parameter int WAIT_CYC = 24
) (
  // timing reference
  input wire logic clk_i,
  // command pins
  output logic ck_t_o,
  output logic ck_c_o,
  output logic reset_n_o,
  output logic cke_o,
  output logic [3:0] cmd_o,
  output logic [2:0] ba_o,
  output logic [15:0] a_o,
  // data pins, one enable for bytes and strobe
  output logic [7:0] dq_o,
  output logic dq_en_o,
  output logic mask_o,
  output logic dqs_t_o,
  output logic dqs_c_o,
  // resolved bus as {strobe_t, strobe_c, byte}
  input wire logic [9:0] bus_i
);
  logic [9:0] rd_q[$];
  initial begin
    {ck_t_o, ck_c_o, reset_n_o, cke_o, cmd_o} = 8'h4f;
    {ba_o, a_o, dq_o, dq_en_o, mask_o, dqs_t_o, dqs_c_o} = '0;
  end
  // clock rests low between frames; four clocks a half, sample at its end clears sync lag
  task automatic half(input logic lvl, input logic smp);
    ck_t_o <= lvl;
    ck_c_o <= ~lvl;
    repeat (4) @(posedge clk_i);
    if (smp) rd_q.push_back(bus_i);
  endtask : half
  task automatic issue(input logic [3:0] c, input logic [2:0] b, input logic [15:0] a,
                       input logic smp);
    @(posedge clk_i);
    cmd_o <= c;
    ba_o <= b;
    a_o <= a;
    repeat (2) @(posedge clk_i);
    half(1'b1, 1'b0);
    cmd_o <= 4'h7;
    half(1'b0, smp);
  endtask : issue
  task automatic power_up;
    @(posedge clk_i);
    reset_n_o <= 1'b0;
    cke_o <= 1'b0;
    repeat (RST_CYC) @(posedge clk_i);
    reset_n_o <= 1'b1;
    repeat (WAIT_CYC) @(posedge clk_i);
    repeat (5) issue(4'hf, 3'h0, 16'h0, 1'b0);
    issue(4'h7, 3'h0, 16'h0, 1'b0);
    cke_o <= 1'b1;
  endtask : power_up
  // strobe edge sits mid-byte
  task automatic wr(input logic [2:0] b, input logic [15:0] a, input logic [7:0] d[8],
                    input logic [7:0] m, input int n);
    @(posedge clk_i);
    {dq_en_o, dqs_t_o, dqs_c_o} <= 3'b101;
    issue(CMD_WR, b, a, 1'b0);
    for (int i = 0; i < n; i++) begin
      dq_o <= d[i];
      mask_o <= m[i];
      repeat (2) @(posedge clk_i);
      dqs_t_o <= ~dqs_t_o;
      dqs_c_o <= dqs_t_o;
      repeat (2) @(posedge clk_i);
    end
    dq_en_o <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] b, input logic [15:0] a, input int n);
    rd_q.delete();
    issue(CMD_RD, b, a, 1'b1);
    for (int i = 1; i < n; i++) half(i[0], 1'b1);
    half(1'b0, 1'b0);
  endtask : rd
endmodule : siaba_ctrl_model
`default_nettype wire

// File: testbench/siaba_dev_tb.sv
// bench for the ddr device: power-up, registers, bursts in every mode
// assumes siaba_ctrl_model stands in for the memory controller
`timescale 1ns/1ps
`default_nettype none
module siaba_dev_tb;
  import siaba_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] seed = 32'd39541;
  logic [7:0] pat = 8'h00;
  logic oe_seen = 1'b0;
  logic th_any = 1'b0;
  logic th_all = 1'b0;
  int n_fail = 0;
  int checks_done = 0;
  logic [7:0] mem [int];
  wire logic [31:0] rdat;
  wire logic ack, ck_t, ck_c, rst_n, cke, wmask, m_en, m_st, m_sc, dq_oe, s_oe, s_t, s_c, tt, tc;
  wire logic [3:0] cmd;
  wire logic [2:0] ba;
  wire logic [15:0] a;
  wire logic [7:0] m_dq, dq_o;
  // released lines carry a moving pattern so no stale byte can pass
  wire logic [7:0] dq = dq_oe ? dq_o : (m_en ? m_dq : pat);
  wire logic st = s_oe ? s_t : (m_en ? m_st : pat[1]);
  wire logic sc = s_oe ? s_c : (m_en ? m_sc : pat[2]);
  siaba_dev #(.INIT_CYC(20)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .cmd_clk_t_i(ck_t), .cmd_clk_c_i(ck_c),
    .reset_n_i(rst_n), .cke_i(cke), .cs_n_i(cmd[3]), .ras_n_i(cmd[2]), .cas_n_i(cmd[1]),
    .we_n_i(cmd[0]), .bank_select_bits_i(ba), .row_col_address_bits_i(a),
    .byte_data_lines_i(dq), .byte_data_lines_o(dq_o), .byte_data_lines_oe_o(dq_oe),
    .write_mask_i(wmask), .dqs_t_i(st), .dqs_c_i(sc), .dqs_t_o(s_t), .dqs_c_o(s_c),
    .dqs_oe_o(s_oe), .term_strobe_true_o(tt), .term_strobe_comp_o(tc));
  siaba_ctrl_model #(.RST_CYC(8), .WAIT_CYC(24)) u_c (.clk_i(clk_i), .ck_t_o(ck_t),
    .ck_c_o(ck_c), .reset_n_o(rst_n), .cke_o(cke), .cmd_o(cmd), .ba_o(ba), .a_o(a),
    .dq_o(m_dq), .dq_en_o(m_en), .mask_o(wmask), .dqs_t_o(m_st), .dqs_c_o(m_sc),
    .bus_i({st, sc, dq}));
  initial forever #20 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    pat <= pat + 8'h1;
    oe_seen <= oe_seen | dq_oe;
    th_any <= th_any | ((tt | tc) & m_en);
    th_all <= th_all | (tt & tc & m_en);
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [2:0] bpos(input logic [2:0] c, input int i, input logic il);
    logic [2:0] k;
    k = i[2:0];
    if (il) return c ^ k;
    return {c[2] ^ k[2], c[1:0] + k[1:0]};
  endfunction : bpos
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, ad, 4'hf, d};
    @(posedge clk_i);
    while (ack !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    q = rdat;
    if (n >= 50) chk(1'b0, 1'b1, "no ack");
    {cyc, stb} <= 2'b00;
    @(posedge clk_i);
  endtask : wb
  // flags cleared off the edge, away from the monitor's updates
  task automatic clr;
    @(negedge clk_i);
    {oe_seen, th_any, th_all} = 3'b000;
  endtask : clr
  task automatic refused(input logic [2:0] b, input logic [15:0] ad);
    logic [31:0] q;
    clr();
    u_c.rd(b, ad, 8);
    chk(oe_seen, 1'b0, "refused read drove bus");
    wb(1'b0, ADR_ERROR, 32'h0, q);
    chk(q[1], 1'b1, "closed bank flag");
    wb(1'b1, ADR_ERROR, 32'h2, q);
    wb(1'b0, ADR_ERROR, 32'h0, q);
    chk(q, 32'h0, "error clear");
  endtask : refused
  task automatic burst(input int t);
    logic [31:0] q, r;
    logic [2:0] b;
    logic [15:0] ad, row;
    logic [7:0] d[8];
    logic [7:0] mk;
    logic il, ts, acl;
    int n, k;
    il = t[0];
    ts = t[1];
    acl = t[0] & (t > 1);
    n = (t < 2 || t == 5) ? 8 : 4;
    r = rnd();
    b = r[2:0];
    row = {12'h0, r[6:3]};
    ad = {3'h0, il, 6'h0, r[12:7]};
    mk = r[20:13];
    wb(1'b1, ADR_MODE0, {28'h0, il, 1'b0, t < 2 ? BL_FIXED8 : (t < 4 ? BL_FIXED4 : BL_OTF)}, q);
    wb(1'b1, ADR_MODE1, {20'h0, ts, 11'h0}, q);
    foreach (d[i]) begin
      r = rnd();
      d[i] = r[7:0];
    end
    clr();
    u_c.issue(CMD_ACT, b, row, 1'b0);
    u_c.wr(b, ad, d, mk, n);
    chk({th_any, th_all}, {ts, ts}, "termination");
    for (int i = 0; i < n; i++) begin
      k = int'({b, row[3:0], ad[5:3], bpos(ad[2:0], i, il)});
      if (ts || !mk[i]) mem[k] = d[i];
    end
    ad[10] = acl;
    u_c.rd(b, ad, n);
    chk({oe_seen, dq_oe}, 2'b10, "bus drive");
    for (int i = 0; i < n; i++) begin
      k = int'({b, row[3:0], ad[5:3], bpos(ad[2:0], i, il)});
      q = {22'h0, u_c.rd_q[i]};
      if (mem.exists(k)) chk(q[7:0], mem[k], "read byte");
      chk(q[9] ^ q[8], 1'b1, "strobe pair");
      if (i > 0) chk(q[9] ^ r[9], 1'b1, "strobe toggle");
      r = q;
    end
    if (acl) refused(b, ad);
  endtask : burst
  initial begin
    logic [31:0] q;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, ADR_MODE0, 32'h0, q);
    chk(q, {16'h0, MODE0_RST}, "mode0 reset");
    wb(1'b0, 8'h10, 32'h0, q);
    chk(q, 32'h0, "unmapped read");
    fork
      u_c.power_up();
      begin
        repeat (16) @(posedge clk_i);
        wb(1'b0, ADR_STATUS, 32'h0, q);
        chk(q[2:0], 3'b011, "status in init");
      end
    join
    wb(1'b1, ADR_STATUS, 32'hffff, q);
    wb(1'b0, ADR_STATUS, 32'h0, q);
    chk(q[15:0], 16'h0006, "status ready");
    for (int t = 0; t < 6; t++) burst(t);
    u_c.issue(CMD_ACT, 3'h5, 16'h3, 1'b0);
    u_c.issue(CMD_PRE, 3'h0, 16'h0400, 1'b0);
    u_c.issue(CMD_ACT | 4'h8, 3'h5, 16'h3, 1'b0);
    wb(1'b0, ADR_STATUS, 32'h0, q);
    chk(q[15:8], 8'h00, "open banks");
    refused(3'h5, 16'h0);
    test_done();
  end
  // budget far above the expected run of under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    $display("wrong value at %0t: timeout", $time);
    n_fail++;
    test_done();
  end
endmodule : siaba_dev_tb
`default_nettype wire
